/* core/clock_divider_doze_config_defines.vh */
// Constants for the clock divisor and PLL feedback register block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
//
// Operation
// - Ratio field frozen while clock reduction enabled
// - Enable cannot set while ratio is 000
// - Peripheral clock is processor clock over two to the ratio
// - Interrupt clears enable when recover bit set
// - Input divider divides by value plus two
`ifndef CLOCK_DIVIDER_DOZE_CONFIG_DEFINES_VH
`define CLOCK_DIVIDER_DOZE_CONFIG_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CLOCK_DIVISOR_CONTROL 4'h0
`define ADDR_PLL_FEEDBACK_DIVISOR 4'h4
`define ADDR_DIVIDER_STATUS 4'h8

// ----------------------------------------------------------------
// Field positions in clock_divisor_control
// ----------------------------------------------------------------
`define POS_RECOVER_ON_INTERRUPT 15
`define POS_RATIO_HI 14
`define POS_RATIO_LO 12
`define POS_CLOCK_REDUCTION_ENABLE 11
`define POS_RC_HI 10
`define POS_RC_LO 8
`define POS_OUT_DIV_HI 7
`define POS_OUT_DIV_LO 6
`define POS_IN_DIV_HI 4
`define POS_IN_DIV_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RECOVER_ON_INTERRUPT 1'h0
`define RST_RATIO 3'h3
`define RST_CLOCK_REDUCTION_ENABLE 1'h0
`define RST_RC_OSC_POSTSCALER 3'h0
`define RST_PLL_OUTPUT_DIVIDER 2'h1
`define RST_PLL_INPUT_DIVIDER 5'h00
`define RST_PLL_FEEDBACK_MULTIPLIER 9'h030

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define RATIO_NONE 3'h0
`define OUT_DIV_BY2 2'h0
`define OUT_DIV_BY4 2'h1
`define OUT_DIV_RESERVED 2'h2
`define OUT_DIV_BY8 2'h3
`define PRESCALE_OFFSET 6'h02
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* core/clock_ratio_divider.v */
// Peripheral clock enable generator for the clock reduction ratio.
// Assumes the ratio only changes while the divider is disabled.
`timescale 1ns/1ps

module clock_ratio_divider #(
  parameter RATIO_W = 3,
  parameter COUNT_W = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Ratio control
  input wire enable,
  input wire [RATIO_W-1:0] ratio,
  // Peripheral clock enable
  output reg periphTick
);

  reg [COUNT_W-1:0] count;
  wire [COUNT_W-1:0] limit;

  // Last count of the period: divisor is two to the ratio
  assign limit = ({{(COUNT_W-1){1'b0}}, 1'b1} << ratio) - {{(COUNT_W-1){1'b0}}, 1'b1};

  // Tick every cycle when disabled, else once per divided period
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= {COUNT_W{1'b0}};
      periphTick <= 1'b0;
    end else if (!enable) begin
      count <= {COUNT_W{1'b0}};
      periphTick <= 1'b1;
    end else if (count >= limit) begin
      count <= {COUNT_W{1'b0}};
      periphTick <= 1'b1;
    end else begin
      count <= count + {{(COUNT_W-1){1'b0}}, 1'b1};
      periphTick <= 1'b0;
    end
  end

endmodule

/* core/clock_divider_doze_config.v */
// Clock divisor and PLL feedback configuration registers with an
// AXI4-Lite slave and a peripheral clock enable for clock reduction.
// Assumes irqEvent is a synchronous pulse from the interrupt controller.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "clock_divider_doze_config_defines.vh"

module clock_divider_doze_config (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // AXI4-Lite write address
  input wire [3:0] awaddr,
  input wire awvalid,
  output reg awready,
  // AXI4-Lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read address
  input wire [3:0] araddr,
  input wire arvalid,
  output reg arready,
  // AXI4-Lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Interrupt event
  input wire irqEvent,
  // Clock system settings
  output reg clockReductionEnable,
  output reg [2:0] rcOscPostscaler,
  output reg [5:0] prescaleFactor,
  output reg [3:0] postscaleFactor,
  output reg [8:0] pllFeedbackMultiplier,
  output wire periphTick
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg recoverOnInterrupt;
  reg [2:0] dozeRatio;
  reg [1:0] pllOutputDivider;
  reg [4:0] pllInputDivider;
  reg [3:0] wrAddr;
  reg [31:0] wrData;
  reg [3:0] wrStrb;
  wire doWrite;
  wire hitControl;
  wire hitFeedback;
  wire hitStatus;
  wire [15:0] controlWord;
  wire [15:0] feedbackWord;
  wire [15:0] statusWord;
  reg [15:0] mergedControl;
  reg [15:0] mergedFeedback;
  reg [2:0] next_dozeRatio;
  reg next_enable;

  // Both address and data held and no response pending
  assign doWrite = !awready && !wready && !bvalid;
  assign hitControl = (wrAddr == `ADDR_CLOCK_DIVISOR_CONTROL);
  assign hitFeedback = (wrAddr == `ADDR_PLL_FEEDBACK_DIVISOR);
  assign hitStatus = (wrAddr == `ADDR_DIVIDER_STATUS);

  // Read views; control bit 5, status bit 3 and unused bits read as zero
  assign controlWord = {recoverOnInterrupt, dozeRatio, clockReductionEnable,
    rcOscPostscaler, pllOutputDivider, 1'b0, pllInputDivider};
  assign feedbackWord = {7'h00, pllFeedbackMultiplier};
  assign statusWord = {2'h0, prescaleFactor, postscaleFactor, 1'b0,
    dozeRatio & {3{clockReductionEnable}}};

  // ----------------------------------------------------------------
  // Write merge with byte strobes and field guards
  // ----------------------------------------------------------------
  // Apply byte lanes, then the ratio and enable guards
  always @* begin
    mergedControl = controlWord;
    mergedFeedback = feedbackWord;
    if (wrStrb[0]) begin
      mergedControl[7:0] = wrData[7:0];
      mergedFeedback[7:0] = wrData[7:0];
    end
    if (wrStrb[1]) begin
      mergedControl[15:8] = wrData[15:8];
      mergedFeedback[15:8] = wrData[15:8];
    end
    // Ratio may only change while reduction is off
    if (clockReductionEnable) begin
      next_dozeRatio = dozeRatio;
    end else begin
      next_dozeRatio = mergedControl[`POS_RATIO_HI:`POS_RATIO_LO];
    end
    // Enable cannot be set while the ratio is 000
    if (next_dozeRatio == `RATIO_NONE) begin
      next_enable = 1'b0;
    end else begin
      next_enable = mergedControl[`POS_CLOCK_REDUCTION_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software writes and the interrupt recovery path
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      recoverOnInterrupt <= `RST_RECOVER_ON_INTERRUPT;
      dozeRatio <= `RST_RATIO;
      clockReductionEnable <= `RST_CLOCK_REDUCTION_ENABLE;
      rcOscPostscaler <= `RST_RC_OSC_POSTSCALER;
      pllOutputDivider <= `RST_PLL_OUTPUT_DIVIDER;
      pllInputDivider <= `RST_PLL_INPUT_DIVIDER;
      pllFeedbackMultiplier <= `RST_PLL_FEEDBACK_MULTIPLIER;
    end else begin
      if (doWrite && hitControl) begin
        recoverOnInterrupt <= mergedControl[`POS_RECOVER_ON_INTERRUPT];
        dozeRatio <= next_dozeRatio;
        clockReductionEnable <= next_enable;
        rcOscPostscaler <= mergedControl[`POS_RC_HI:`POS_RC_LO];
        pllOutputDivider <= mergedControl[`POS_OUT_DIV_HI:`POS_OUT_DIV_LO];
        pllInputDivider <= mergedControl[`POS_IN_DIV_HI:`POS_IN_DIV_LO];
      end
      if (doWrite && hitFeedback) begin
        pllFeedbackMultiplier <= mergedFeedback[8:0];
      end
      // Interrupt wins over a same-cycle write of the enable
      if (irqEvent && recoverOnInterrupt) begin
        clockReductionEnable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Derived division factors
  // ----------------------------------------------------------------
  // Prescale is code plus two, postscale decoded from the code
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prescaleFactor <= `PRESCALE_OFFSET;
      postscaleFactor <= 4'h4;
    end else begin
      prescaleFactor <= {1'b0, pllInputDivider} + `PRESCALE_OFFSET;
      case (pllOutputDivider)
        `OUT_DIV_BY2: postscaleFactor <= 4'h2;
        `OUT_DIV_BY4: postscaleFactor <= 4'h4;
        `OUT_DIV_BY8: postscaleFactor <= 4'h8;
        default: postscaleFactor <= 4'h0; // Reserved code gives no factor
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peripheral clock enable
  // ----------------------------------------------------------------
  clock_ratio_divider #(
    .RATIO_W(3),
    .COUNT_W(8)
  ) ratioDivider (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(clockReductionEnable),
    .ratio(dozeRatio),
    .periphTick(periphTick)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Capture address and data in either order, then respond
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      wrAddr <= 4'h0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end else begin
      if (awready && awvalid) begin
        awready <= 1'b0;
        wrAddr <= {awaddr[3:2], 2'h0};
      end
      if (wready && wvalid) begin
        wready <= 1'b0;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (hitControl || hitFeedback || hitStatus) ? `RESP_OKAY : `RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  // One read at a time, answered the cycle after the address
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case ({araddr[3:2], 2'h0})
          `ADDR_CLOCK_DIVISOR_CONTROL: rdata <= {16'h0000, controlWord};
          `ADDR_PLL_FEEDBACK_DIVISOR: rdata <= {16'h0000, feedbackWord};
          `ADDR_DIVIDER_STATUS: rdata <= {16'h0000, statusWord};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_DECERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

/* tb/clock_divider_doze_config_checker.sv */
// Bus and divider checks for the clock divisor register block.
// Assumes binding to the top module and sight of its ports alone.
`timescale 1ns/1ps
module clock_divider_doze_config_checker (
  // Clock and reset
  input logic ref_clk,
  input logic nrst,
  // Bus handshakes
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic [31:0] rdata,
  input logic bvalid,
  input logic bready,
  input logic [1:0] bresp,
  // Clock settings
  input logic clockReductionEnable,
  input logic [5:0] prescaleFactor,
  input logic [3:0] postscaleFactor,
  input logic periphTick
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_tick_full: assert property ($past(nrst) && !$past(clockReductionEnable) |->
    periphTick)
    else $error("tick missing with reduction off");
  a_enable_cause: assert property ($rose(clockReductionEnable) |-> $rose(bvalid))
    else $error("enable set without a write");
  a_pre_range: assert property (prescaleFactor >= 6'h02 && prescaleFactor <= 6'h21)
    else $error("prescale factor out of range");
  a_pre_cause: assert property ($changed(prescaleFactor) |-> $past(bvalid))
    else $error("prescale factor moved without a write");
  a_post_legal: assert property (postscaleFactor inside {4'h0, 4'h2, 4'h4, 4'h8})
    else $error("postscale factor illegal");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  // Main scenarios reached
  cover property (bvalid && bready);
  cover property ($fell(clockReductionEnable));
  cover property (clockReductionEnable && periphTick);
endmodule

bind clock_divider_doze_config clock_divider_doze_config_checker u_chk (.ref_clk(ref_clk),
  .nrst(nrst), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .clockReductionEnable(clockReductionEnable), .prescaleFactor(prescaleFactor),
  .postscaleFactor(postscaleFactor), .periphTick(periphTick));

/* tb/tb.sv */
// Self-checking bench for the clock divisor register block.
// Assumes an AXI4-Lite slave running from one 200 MHz clock.
`timescale 1ns/1ps
module tb;
  logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, irqEvent;
  logic awready, wready, bvalid, arready, rvalid, clockReductionEnable, periphTick;
  logic [3:0] awaddr, araddr, wstrb, postscaleFactor;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] wdata, rdata, got;
  logic [2:0] rcOscPostscaler;
  logic [5:0] prescaleFactor;
  logic [8:0] pllFeedbackMultiplier;
  integer errors, compares, cyc, k;

  clock_divider_doze_config u_clock_divider_doze_config (.ref_clk(ref_clk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irqEvent(irqEvent),
    .clockReductionEnable(clockReductionEnable), .rcOscPostscaler(rcOscPostscaler),
    .prescaleFactor(prescaleFactor), .postscaleFactor(postscaleFactor),
    .pllFeedbackMultiplier(pllFeedbackMultiplier), .periphTick(periphTick));

  // ------
  // Bus and check tasks
  // ------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write one word; bready stands until the response is seen
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask

  // Read one word and compare it
  task rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'h0;
    chk(nm, got, exp);
  endtask

  // Count peripheral ticks over a window
  task ticks(input integer n);
    repeat (10) @(posedge ref_clk);
    k = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (periphTick === 1'h1) k++;
    end
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task t_reset;
    rd(4'h0, 32'h3040, "control");
    rd(4'h4, 32'h0030, "feedback");
    chk("postscale", postscaleFactor, 4'h4);
    $display("reset test done");
  endtask

  task t_divs;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 32'h3000 | (i << 6) | (i * 10 + 1));
      repeat (2) @(posedge ref_clk);
      chk("prescale", prescaleFactor, i * 10 + 3);
      chk("postscale", postscaleFactor, 16'h8042 >> (i * 4) & 4'hF);
    end
    $display("divider test done");
  endtask

  task t_doze;
    wr(4'h0, 32'h3800);
    ticks(64);
    chk("ticks", k, 8);
    rd(4'h8, 32'h0223, "status");
    wr(4'h0, 32'h5800);
    rd(4'h0, 32'h3800, "ratio");
    wr(4'h0, 32'h0000);
    rd(4'h0, 32'h3000, "ratio");
    wr(4'h0, 32'h0800);
    rd(4'h0, 32'h0000, "enable");
    ticks(16);
    chk("ticks", k, 16);
    $display("reduction test done");
  endtask

  task t_irq(input logic [31:0] d, input logic [31:0] exp);
    wr(4'h0, d);
    @(posedge ref_clk);
    irqEvent <= 1'h1;
    @(posedge ref_clk);
    irqEvent <= 1'h0;
    rd(4'h0, exp, "recover");
    chk("enable", clockReductionEnable, exp[11]);
    $display("interrupt test done");
  endtask

  task t_bus;
    rd(4'hC, 32'h0000, "unmapped");
    chk("rresp", resp, 2'h3);
    wr(4'hC, 32'hFFFF);
    chk("bresp", resp, 2'h3);
    wr(4'h4, 32'hFFFF);
    rd(4'h4, 32'h01FF, "feedback");
    chk("multiplier", pllFeedbackMultiplier, 9'h1FF);
    wr(4'h0, 32'h35FF);
    rd(4'h0, 32'h35DF, "control");
    chk("rc postscaler", rcOscPostscaler, 3'h5);
    wr(4'h8, 32'hFFFF);
    chk("bresp", resp, 2'h0);
    rd(4'h8, 32'h2180, "status");
    // Low byte lane only: upper fields keep their values
    wstrb <= 4'h1;
    wr(4'h0, 32'h0000);
    wstrb <= 4'hF;
    rd(4'h0, 32'h3500, "low lane");
    $display("bus test done");
  endtask

  // Clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Main sequence
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, irqEvent} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    errors = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    t_reset;
    t_divs;
    t_doze;
    t_irq(32'h3800, 32'h3800);
    t_irq(32'hB800, 32'hB000);
    t_bus;
    give_verdict;
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict;
    end
  end
endmodule
